// ==== design/ciu_pkg.sv ====
// constants shared by the cascaded interrupt unit
// ==========================================================================
// Contract
// - two cascaded controllers take ten external and eight internal requests
// - slave requests reach the core only through the master cascade input
// - nested priority: highest pending served first, higher preempts lower except a slave line over a slave line in service
// - writing 0x20 to an op command word clears the highest in-service bit
// - master op command word sits at i/o address 0xf020
// - all ten external lines start disabled, each line has its own enable
// - the non-maskable input always reaches the core, nothing masks it
// - external lines four to seven are active low, zero to three active high
package ciu_pkg;
  // ========================================================================
  // i/o addresses
  localparam logic [15:0] CIU_MASTER_OCW_ADDR = 16'hf020;
  localparam logic [15:0] CIU_SLAVE_OCW_ADDR = 16'hf0a0;
  localparam logic [15:0] CIU_SRC_CFG_ADDR = 16'hf832;
  localparam logic [15:0] CIU_EN_LO_ADDR = 16'hf8f0;
  localparam logic [15:0] CIU_EN_HI_ADDR = 16'hf8f2;
  localparam logic [15:0] CIU_MASTER_ISR_ADDR = 16'hf8f4;
  localparam logic [15:0] CIU_SLAVE_ISR_ADDR = 16'hf8f6;
  // ========================================================================
  // codes and reset values
  localparam logic [7:0] CIU_EOI_NONSPEC = 8'h20;
  localparam logic [7:0] CIU_SRC_CFG_RESET = 8'h00;
  localparam logic [9:0] CIU_EN_RESET = 10'h000;
  localparam logic [2:0] CIU_CASCADE_IR = 3'h2;
  localparam int CIU_NUM_EXT = 10;
  localparam int CIU_NUM_INTERNAL = 8;
  localparam int CIU_NUM_IR = 8;
endpackage

// ==== design/ciu_ctrl_if.sv ====
// link between the top and one priority controller
`timescale 1ns/1ps
`default_nettype none
interface ciu_ctrl_if;
  logic [7:0] ir;
  logic ack;
  logic [2:0] ack_idx;
  logic eoi;
  logic req;
  logic [2:0] idx;
  logic [7:0] isr;
  modport ctrl (input ir, input ack, input ack_idx, input eoi, output req, output idx, output isr);
  modport top (output ir, output ack, output ack_idx, output eoi, input req, input idx, input isr);
endinterface
`default_nettype wire

// ==== design/ciu_ctrl.sv ====
// one eight-input fully nested priority controller
`timescale 1ns/1ps
`default_nettype none
module ciu_ctrl
  import ciu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  ciu_ctrl_if.ctrl bus
);
  logic [7:0] isr_q;
  logic [7:0] isr_d;
  logic [2:0] pend_idx;
  logic [2:0] srv_idx;
  logic pend_any;
  logic srv_any;

  // ========================================================================
  // priority search, lowest index wins
  always_comb
  begin
    pend_idx = 3'h0;
    srv_idx = 3'h0;
    pend_any = 1'b0;
    srv_any = 1'b0;
    for (int i = CIU_NUM_IR - 1; i >= 0; i--)
    begin
      if (bus.ir[i])
      begin
        pend_idx = i[2:0];
        pend_any = 1'b1;
      end
      if (isr_q[i])
      begin
        srv_idx = i[2:0];
        srv_any = 1'b1;
      end
    end
  end

  // ========================================================================
  // in-service next state; a set in the same cycle as an eoi wins
  always_comb
  begin
    isr_d = isr_q;
    if (bus.eoi && srv_any)
    begin
      isr_d[srv_idx] = 1'b0;
    end
    if (bus.ack)
    begin
      isr_d[bus.ack_idx] = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      isr_q <= 8'h00;
    end
    else
    begin
      isr_q <= isr_d;
    end
  end

  // equal or lower priority stays blocked until its eoi
  assign bus.req = pend_any && (!srv_any || (pend_idx < srv_idx));
  assign bus.idx = pend_idx;
  assign bus.isr = isr_q;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_eoi_clears_top: assert property (bus.eoi && srv_any && !bus.ack |=>
    isr_q == ($past(isr_q) & ~(8'h01 << $past(srv_idx))))
    else $error("eoi did not clear highest in-service bit");
  a_ack_sets_bit: assert property (bus.ack |=> isr_q[$past(bus.ack_idx)])
    else $error("ack did not set in-service bit");
  a_top_blocks_all: assert property (isr_q[0] |-> !bus.req)
    else $error("request while top priority in service");
  a_input0_wins: assert property (bus.ir[0] && !isr_q[0] |-> bus.req && bus.idx == 3'h0)
    else $error("input 0 not ranked highest");
  c_preempt: cover property (srv_any && bus.req);
  c_eoi_seen: cover property (bus.eoi && srv_any);
endmodule // ciu_ctrl
`default_nettype wire

// ==== design/ciu_top.sv ====
// cascaded interrupt unit: master and slave controllers, masks, i/o decode
`timescale 1ns/1ps
`default_nettype none
module ciu_top
  import ciu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  output logic [7:0] o_io_rdata,
  input wire logic [3:0] i_high_active_request_inputs,
  input wire logic [3:0] i_low_active_request_inputs_n,
  input wire logic [1:0] i_ext_req_upper,
  input wire logic [7:0] i_internal_req,
  input wire logic i_nmi,
  input wire logic i_int_ack,
  output logic o_int_req,
  output logic [3:0] o_int_id,
  output logic o_nmi
);
  logic [9:0] en_q;
  logic [9:0] en_d;
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic req_q;
  logic req_d;
  logic [3:0] id_q;
  logic [3:0] id_d;
  logic nmi_q;
  logic nmi_d;
  logic [9:0] ext_lvl;
  logic [9:0] ext_req;
  logic ack_ok;

  ciu_ctrl_if m_if ();
  ciu_ctrl_if s_if ();

  // ========================================================================
  // external line polarity and per-line enable
  assign ext_lvl[3:0] = i_high_active_request_inputs;
  assign ext_lvl[9:8] = i_ext_req_upper;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_low_lines
      assign ext_lvl[4 + g] = ~i_low_active_request_inputs_n[g];
    end
    for (g = 0; g < CIU_NUM_EXT; g++)
    begin : g_mask
      assign ext_req[g] = ext_lvl[g] & en_q[g];
    end
  endgenerate

  // ========================================================================
  // request routing: lines 2..9 on the slave, the rest and internals on the master
  // internal sources five to seven share slots with zero to two, so they cannot be told apart
  assign s_if.ir = ext_req[9:2];
  assign m_if.ir = {i_internal_req[4],
                    i_internal_req[3],
                    i_internal_req[2] | i_internal_req[7],
                    i_internal_req[1] | i_internal_req[6],
                    ext_req[1],
                    s_if.req,
                    ext_req[0],
                    i_internal_req[0] | i_internal_req[5]};

  // ========================================================================
  // acknowledge works on the id the core saw, not on a later winner
  assign ack_ok = i_int_ack && req_q;
  assign m_if.ack = ack_ok;
  assign m_if.ack_idx = id_q[3] ? CIU_CASCADE_IR : id_q[2:0];
  assign s_if.ack = ack_ok && id_q[3];
  assign s_if.ack_idx = id_q[2:0];

  // each controller has its own eoi word; no cross-clearing, software does both
  assign m_if.eoi = i_io_wr && (i_io_addr == CIU_MASTER_OCW_ADDR) && (i_io_wdata == CIU_EOI_NONSPEC);
  assign s_if.eoi = i_io_wr && (i_io_addr == CIU_SLAVE_OCW_ADDR) && (i_io_wdata == CIU_EOI_NONSPEC);

  ciu_ctrl u_master (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .bus(m_if.ctrl)
  );

  ciu_ctrl u_slave (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .bus(s_if.ctrl)
  );

  // ========================================================================
  // register writes, reads and core-facing outputs
  always_comb
  begin
    en_d = en_q;
    cfg_d = cfg_q;
    rdata_d = rdata_q;
    nmi_d = i_nmi;
    if (i_io_wr)
    begin
      case (i_io_addr)
        CIU_EN_LO_ADDR: en_d[7:0] = i_io_wdata;
        CIU_EN_HI_ADDR: en_d[9:8] = i_io_wdata[1:0];
        CIU_SRC_CFG_ADDR: cfg_d = i_io_wdata;
        default: cfg_d = cfg_q;
      endcase
    end
    if (i_io_rd)
    begin
      case (i_io_addr)
        CIU_EN_LO_ADDR: rdata_d = en_q[7:0];
        CIU_EN_HI_ADDR: rdata_d = {6'h00, en_q[9:8]};
        CIU_SRC_CFG_ADDR: rdata_d = cfg_q;
        CIU_MASTER_ISR_ADDR: rdata_d = m_if.isr;
        CIU_SLAVE_ISR_ADDR: rdata_d = s_if.isr;
        default: rdata_d = 8'h00;
      endcase
    end
    // slave winner reported with the slave flag set
    req_d = m_if.req;
    if (m_if.idx == CIU_CASCADE_IR)
    begin
      id_d = {1'b1, s_if.idx};
    end
    else
    begin
      id_d = {1'b0, m_if.idx};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      en_q <= CIU_EN_RESET;
      cfg_q <= CIU_SRC_CFG_RESET;
      rdata_q <= 8'h00;
      req_q <= 1'b0;
      id_q <= 4'h0;
      nmi_q <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      req_q <= req_d;
      id_q <= id_d;
      nmi_q <= nmi_d;
    end
  end

  assign o_io_rdata = rdata_q;
  assign o_int_req = req_q;
  assign o_int_id = id_q;
  assign o_nmi = nmi_q;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_nmi_bypass: assert property (##1 o_nmi == $past(i_nmi))
    else $error("nmi not delivered");
  a_mask_reset: assert property (disable iff (1'b0) !i_resetn |=> en_q == 10'h000)
    else $error("lines not disabled after reset");
  a_disabled_quiet: assert property (!en_q[0] && !en_q[1] |-> !m_if.ir[1] && !m_if.ir[3])
    else $error("disabled line reached master");
  a_slave_via_cascade: assert property (o_int_req && o_int_id[3] |-> $past(m_if.idx) == CIU_CASCADE_IR)
    else $error("slave id without cascade input");
  a_master_eoi: assert property (m_if.eoi && m_if.isr != 8'h00 && !ack_ok |=>
    $countones(m_if.isr) == $countones($past(m_if.isr)) - 1)
    else $error("master eoi write had no effect");
  a_low_active: assert property (en_q[4] && !i_low_active_request_inputs_n[0] |-> s_if.ir[2])
    else $error("active low line not seen");

  // reset clears the core request and both in-service words
  a_reset_clear: assert property (disable iff (1'b0) !i_resetn |=>
    !o_int_req && m_if.isr == 8'h00 && s_if.isr == 8'h00)
    else $error("reset left request or in-service state");

  // lines eight and nine land on the top slave inputs
  a_upper_lines: assert property (en_q[9] && i_ext_req_upper[1] |-> s_if.ir[7])
    else $error("upper external line not routed");

  // line zero is active high on master input one
  a_high_active: assert property (en_q[0] && i_high_active_request_inputs[0] |-> m_if.ir[1])
    else $error("active high line not seen");

  // nmi gets through even with every line disabled
  a_nmi_unmasked: assert property (en_q == 10'h000 && i_nmi |=> o_nmi)
    else $error("nmi suppressed by enables");

  // a slave ack also puts the cascade input in service
  a_slave_ack_casc: assert property (s_if.ack |=> m_if.isr[CIU_CASCADE_IR])
    else $error("slave ack left cascade input idle");

  // slave eoi drops exactly one in-service bit
  a_slave_eoi: assert property (s_if.eoi && s_if.isr != 8'h00 && !s_if.ack |=>
    $countones(s_if.isr) == $countones($past(s_if.isr)) - 1)
    else $error("slave eoi write had no effect");

  // only the exact eoi code touches the master in-service word
  a_eoi_code_only: assert property (i_io_wr && i_io_addr == CIU_MASTER_OCW_ADDR &&
    i_io_wdata != CIU_EOI_NONSPEC && !ack_ok |=> m_if.isr == $past(m_if.isr))
    else $error("non-eoi write changed master in-service");

  // a master id never names the cascade slot
  a_master_id: assert property (o_int_req && !o_int_id[3] |-> o_int_id[2:0] != CIU_CASCADE_IR)
    else $error("master id points at cascade input");

  c_slave_ack: cover property (ack_ok && id_q[3]);
  c_nmi_seen: cover property (o_nmi);
  c_master_ack: cover property (ack_ok && !id_q[3]);
endmodule // ciu_top
`default_nettype wire

// ==== verification/ciu_core_model.sv ====
// core model: acks interrupt requests after a set lag
`timescale 1ns/1ps
`default_nettype none
module ciu_core_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [3:0] i_lag,
  input wire logic i_int_req,
  output logic o_int_ack
);
  int cnt = 0;
  initial o_int_ack = 1'b0;
  // ==========================================================
  // one-cycle ack; hold-off lets the request drop, no double ack
  always @(posedge i_clk)
  begin
    #1;
    o_int_ack = 1'b0;
    cnt = (i_go && i_int_req) ? cnt + 1 : 0;
    if (cnt > int'(i_lag)) // signed compare, so the negative hold-off never acks
    begin
      o_int_ack = 1'b1;
      cnt = -3;
    end
  end
endmodule // ciu_core_model
`default_nettype wire

// ==== verification/tb_cascaded_interrupt_unit.sv ====
// self-checking bench for the cascaded interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb_cascaded_interrupt_unit;
  import ciu_pkg::*;
  logic i_clk = 0, i_resetn = 0, io_wr = 0, io_rd = 0, nmi = 0, go = 0;
  logic [15:0] io_addr = 0;
  logic [7:0] io_wdata = 0, intr = 0, rdata;
  logic [3:0] hi = 0, lo_n = 4'hf, lag = 0, int_id;
  logic [1:0] up = 0;
  logic ack, int_req, nmi_out;
  int n_fail = 0, checks = 0, cyc = 0;
  ciu_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_io_addr(io_addr), .i_io_wdata(io_wdata),
    .i_io_wr(io_wr), .i_io_rd(io_rd), .o_io_rdata(rdata), .i_high_active_request_inputs(hi),
    .i_low_active_request_inputs_n(lo_n), .i_ext_req_upper(up), .i_internal_req(intr),
    .i_nmi(nmi), .i_int_ack(ack), .o_int_req(int_req), .o_int_id(int_id), .o_nmi(nmi_out));
  ciu_core_model core (.i_clk(i_clk), .i_go(go), .i_lag(lag), .i_int_req(int_req), .o_int_ack(ack));
  // ==========================================================
  // clock and hang guard
  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // every step lands 1 ns after an edge, off the sampling point
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    tick(1);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
  endtask
  // read data is registered; look one cycle later where it stands
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    tick(1);
    io_addr = a;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    tick(1);
    chk(nm, rdata, e);
  endtask
  task automatic t_reset();
    chk("req", {7'h0, int_req}, 8'h00);
    rd(CIU_EN_LO_ADDR, 8'h00, "en_lo");
    rd(CIU_EN_HI_ADDR, 8'h00, "en_hi");
    wr(CIU_EN_HI_ADDR, 8'hff);
    rd(CIU_EN_HI_ADDR, 8'h03, "en_hi_w");
    wr(CIU_EN_HI_ADDR, 8'h00);
    rd(CIU_SRC_CFG_ADDR, CIU_SRC_CFG_RESET, "cfg");
    wr(CIU_SRC_CFG_ADDR, 8'h5a);
    rd(CIU_SRC_CFG_ADDR, 8'h5a, "cfg_rw");
    wr(CIU_SRC_CFG_ADDR, 8'h00);
    rd(CIU_SRC_CFG_ADDR, 8'h00, "cfg0");
    rd(16'hf8fe, 8'h00, "unmapped");
  endtask
  // slow core; masked line, then enabled, acked and ended
  task automatic t_mask();
    hi[0] = 1'b1;
    tick(4);
    chk("masked", {7'h0, int_req}, 8'h00);
    wr(CIU_EN_LO_ADDR, 8'h01);
    tick(4);
    chk("id", {int_req, 3'h0, int_id}, 8'h81);
    lag = 4'h3;
    go = 1'b1;
    tick(10);
    chk("req_off", {7'h0, int_req}, 8'h00);
    rd(CIU_MASTER_ISR_ADDR, 8'h02, "isr");
    hi[0] = 1'b0;
    wr(CIU_MASTER_OCW_ADDR, 8'h21);
    rd(CIU_MASTER_ISR_ADDR, 8'h02, "bad_eoi");
    wr(CIU_MASTER_OCW_ADDR, CIU_EOI_NONSPEC);
    rd(CIU_MASTER_ISR_ADDR, 8'h00, "eoi");
    go = 1'b0;
    lag = 4'h0;
  endtask
  // active-low line on the slave goes through cascade input
  task automatic t_slave();
    wr(CIU_EN_LO_ADDR, 8'h10);
    lo_n[0] = 1'b0;
    tick(4);
    chk("sid", {int_req, 3'h0, int_id}, 8'h8a);
    go = 1'b1;
    tick(8);
    rd(CIU_MASTER_ISR_ADDR, 8'h04, "m_isr");
    rd(CIU_SLAVE_ISR_ADDR, 8'h04, "s_isr");
    wr(CIU_EN_LO_ADDR, 8'h00);
    wr(CIU_SLAVE_OCW_ADDR, CIU_EOI_NONSPEC);
    rd(CIU_SLAVE_ISR_ADDR, 8'h00, "s_eoi");
    rd(CIU_MASTER_ISR_ADDR, 8'h04, "m_hold");
    wr(CIU_MASTER_OCW_ADDR, CIU_EOI_NONSPEC);
    rd(CIU_MASTER_ISR_ADDR, 8'h00, "m_eoi");
    chk("no_rearm", {7'h0, int_req}, 8'h00);
    lo_n[0] = 1'b1;
    go = 1'b0;
  endtask
  // lower blocked, higher preempts, eoi clears the top bit
  task automatic t_nest();
    wr(CIU_EN_LO_ADDR, 8'h02);
    hi[1] = 1'b1;
    go = 1'b1;
    tick(8);
    rd(CIU_MASTER_ISR_ADDR, 8'h08, "isr3");
    intr[2] = 1'b1;
    tick(4);
    chk("blocked", {7'h0, int_req}, 8'h00);
    intr[2] = 1'b0;
    intr[0] = 1'b1;
    tick(8);
    rd(CIU_MASTER_ISR_ADDR, 8'h09, "preempt");
    intr[0] = 1'b0;
    hi[1] = 1'b0;
    wr(CIU_MASTER_OCW_ADDR, CIU_EOI_NONSPEC);
    rd(CIU_MASTER_ISR_ADDR, 8'h08, "eoi_top");
    wr(CIU_MASTER_OCW_ADDR, CIU_EOI_NONSPEC);
    rd(CIU_MASTER_ISR_ADDR, 8'h00, "eoi_all");
    go = 1'b0;
  endtask
  task automatic t_nmi();
    nmi = 1'b1;
    tick(2);
    chk("nmi", {7'h0, nmi_out}, 8'h01);
    nmi = 1'b0;
    tick(2);
    chk("nmi_off", {7'h0, nmi_out}, 8'h00);
  endtask
  // slave lines and master internals ranked by fixed priority, no acks
  task automatic t_route();
    wr(CIU_EN_LO_ADDR, 8'h0c);
    wr(CIU_EN_HI_ADDR, 8'h02);
    up[1] = 1'b1;
    tick(3);
    chk("up9", {int_req, 3'h0, int_id}, 8'h8f);
    hi[3] = 1'b1;
    tick(3);
    chk("slv_rank", {int_req, 3'h0, int_id}, 8'h89);
    intr[7] = 1'b1;
    tick(3);
    chk("casc_rank", {int_req, 3'h0, int_id}, 8'h89);
    intr[5] = 1'b1;
    tick(3);
    chk("int_rank", {int_req, 3'h0, int_id}, 8'h80);
    intr = 8'h00;
    hi[3] = 1'b0;
    up[1] = 1'b0;
    hi[2] = 1'b1;
    tick(3);
    chk("slv_in0", {int_req, 3'h0, int_id}, 8'h88);
    hi[2] = 1'b0;
    wr(CIU_EN_LO_ADDR, 8'h00);
    wr(CIU_EN_HI_ADDR, 8'h00);
    chk("route_off", {7'h0, int_req}, 8'h00);
  endtask
  // reset in mid-run clears enables and in-service state
  task automatic t_rst_mid();
    wr(CIU_EN_LO_ADDR, 8'h01);
    hi[0] = 1'b1;
    go = 1'b1;
    tick(6);
    rd(CIU_MASTER_ISR_ADDR, 8'h02, "pre_rst");
    go = 1'b0;
    hi[0] = 1'b0;
    i_resetn = 1'b0;
    tick(2);
    i_resetn = 1'b1;
    chk("rst_req", {7'h0, int_req}, 8'h00);
    rd(CIU_EN_LO_ADDR, 8'h00, "rst_en");
    rd(CIU_MASTER_ISR_ADDR, 8'h00, "rst_isr");
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    tick(6);
    i_resetn = 1'b1;
    t_reset();
    t_mask();
    t_slave();
    t_nest();
    t_route();
    t_nmi();
    t_rst_mid();
    finish_test();
  end
endmodule // tb_cascaded_interrupt_unit
`default_nettype wire
